/* File: core/cce_pkg.sv */
// Constants for the configuration chain enable control block.
package cce_pkg;
	// ==========================================================
	// Boot modes
	localparam logic [1:0] MODE_PASSIVE = 2'h0;
	localparam logic [1:0] MODE_ACTIVE_SERIAL = 2'h1;
	localparam logic [1:0] MODE_ACTIVE_PARALLEL = 2'h2;
	// ==========================================================
	// Reset values
	localparam logic RST_CHAIN_OUT_OE = 1'b0;
	localparam logic RST_SELECT_N = 1'b1;
	// ==========================================================
	// Controller states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_LOAD = 4'h2,
		ST_INIT = 4'h4,
		ST_USER = 4'h8
	} cce_state_t;
endpackage

/* File: core/cce_sync.sv */
// Two-flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/100ps
module cce_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage1;

	// ==========================================================
	// Synchroniser
	// Each bit passes two flops; reset loads all-ones then follows the pin.
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge i_mclk or posedge i_rst) begin
				if (i_rst) begin
					stage1[g] <= 1'b1;
					o_sync[g] <= 1'b1;
				end else begin
					stage1[g] <= i_async[g];
					o_sync[g] <= stage1[g];
				end
			end
		end
	endgenerate
endmodule

/* File: core/cce_ctrl.sv */
// Chain enable and boot-memory select control for a configurable device.
// Contract
// - configure only while chain enable input low
// - drive chain enable output low when done
// - option off makes output a user pin
// - active serial selects serial boot memory
// - active parallel enables flash chip enable
`timescale 1ns/100ps
module cce_ctrl (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_chain_enable_in_n,
	input wire logic [1:0] i_boot_mode,
	input wire logic i_load_start,
	input wire logic i_load_done,
	input wire logic i_init_done,
	input wire logic i_dual_purpose_on,
	input wire logic i_user_out,
	input wire logic i_user_oe,
	input wire logic i_chain_enable_out_pin,
	output logic o_load_enable,
	output logic o_load_active,
	output logic o_config_done,
	output logic o_user_in,
	output logic o_chain_enable_out_n_o,
	output logic o_chain_enable_out_n_oe,
	output logic o_serial_boot_select_n,
	output logic o_parallel_boot_select_n
);
	logic [1:0] pins_sync;
	logic ce_n;
	logic chain_pin;
	cce_pkg::cce_state_t state;
	cce_pkg::cce_state_t next_state;
	logic active_serial_boot;
	logic active_parallel_boot;
	logic next_oe;
	logic next_out;

	// ==========================================================
	// Pin synchronisation
	// The enable pin and the chain output readback come from outside.
	cce_sync #(
		.WIDTH(2)
	) u_sync (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_async({i_chain_enable_out_pin, i_chain_enable_in_n}),
		.o_sync(pins_sync)
	);
	assign ce_n = pins_sync[0];
	assign chain_pin = pins_sync[1];

	assign active_serial_boot = (i_boot_mode == cce_pkg::MODE_ACTIVE_SERIAL);
	assign active_parallel_boot = (i_boot_mode == cce_pkg::MODE_ACTIVE_PARALLEL);

	// ==========================================================
	// Configuration sequence
	// Next state; a high enable input aborts any load and blocks starting.
	always_comb begin
		next_state = state;
		unique case (state)
			cce_pkg::ST_IDLE: begin
				if (!ce_n && i_load_start) begin
					next_state = cce_pkg::ST_LOAD;
				end
			end
			cce_pkg::ST_LOAD: begin
				if (ce_n) begin
					next_state = cce_pkg::ST_IDLE;
				end else if (i_load_done) begin
					next_state = cce_pkg::ST_INIT;
				end
			end
			cce_pkg::ST_INIT: begin
				if (i_init_done) begin
					next_state = cce_pkg::ST_USER;
				end
			end
			cce_pkg::ST_USER: begin
				next_state = cce_pkg::ST_USER;
			end
			default: begin
				next_state = cce_pkg::ST_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state <= cce_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Loading is allowed only while the synchronised enable is low.
	assign o_load_enable = !ce_n;
	assign o_load_active = (state == cce_pkg::ST_LOAD);

	// Done flag follows the sequence past the data load.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_config_done <= 1'b0;
		end else begin
			o_config_done <= (next_state == cce_pkg::ST_INIT) || (next_state == cce_pkg::ST_USER);
		end
	end

	// ==========================================================
	// Chain enable output
	// Open drain: released until done, then pulled low; in user mode with the
	// option off the pin follows the user drive instead.
	always_comb begin
		next_oe = cce_pkg::RST_CHAIN_OUT_OE;
		next_out = 1'b0;
		if (next_state == cce_pkg::ST_INIT || next_state == cce_pkg::ST_USER) begin
			next_oe = 1'b1;
		end
		if (next_state == cce_pkg::ST_USER && !i_dual_purpose_on) begin
			next_oe = i_user_oe;
			next_out = i_user_out;
		end
	end

	// Registered pin drive.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_chain_enable_out_n_oe <= cce_pkg::RST_CHAIN_OUT_OE;
			o_chain_enable_out_n_o <= 1'b0;
		end else begin
			o_chain_enable_out_n_oe <= next_oe;
			o_chain_enable_out_n_o <= next_out;
		end
	end

	// Input path of the pin when used as a user pin.
	assign o_user_in = chain_pin;

	// ==========================================================
	// Boot memory selects
	// Each select is active low only in its own mode while loading.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_serial_boot_select_n <= cce_pkg::RST_SELECT_N;
			o_parallel_boot_select_n <= cce_pkg::RST_SELECT_N;
		end else begin
			o_serial_boot_select_n <= !(active_serial_boot &&
				next_state == cce_pkg::ST_LOAD);
			o_parallel_boot_select_n <= !(active_parallel_boot &&
				next_state == cce_pkg::ST_LOAD);
		end
	end

	// ==========================================================
	// Checks
	a_released_before_done: assert property (@(posedge i_mclk) disable iff (i_rst)
		!o_config_done |-> !o_chain_enable_out_n_oe)
		else $error("chain output driven before done");
	a_driven_low_done: assert property (@(posedge i_mclk) disable iff (i_rst)
		(o_config_done && (i_dual_purpose_on || state == cce_pkg::ST_INIT))
		|-> (o_chain_enable_out_n_oe && !o_chain_enable_out_n_o))
		else $error("chain output not low after done");
	a_load_needs_enable: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(o_load_active) |-> $past(!ce_n))
		else $error("load began with enable high");
	a_abort_on_high: assert property (@(posedge i_mclk) disable iff (i_rst)
		(o_load_active && ce_n) |=> !o_load_active)
		else $error("load continued with enable high");
	a_serial_select: assert property (@(posedge i_mclk) disable iff (i_rst)
		(o_load_active && active_serial_boot && $stable(i_boot_mode))
		|-> !o_serial_boot_select_n)
		else $error("serial select missing while loading");
	a_parallel_select: assert property (@(posedge i_mclk) disable iff (i_rst)
		(o_load_active && active_parallel_boot && $stable(i_boot_mode))
		|-> !o_parallel_boot_select_n)
		else $error("parallel select missing while loading");
	a_selects_idle: assert property (@(posedge i_mclk) disable iff (i_rst)
		!o_load_active |-> (o_serial_boot_select_n && o_parallel_boot_select_n))
		else $error("select active outside loading");
	a_user_pin_mode: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state == cce_pkg::ST_USER && !i_dual_purpose_on) |=>
		(state != cce_pkg::ST_USER || i_dual_purpose_on ||
		o_chain_enable_out_n_oe == $past(i_user_oe)))
		else $error("user pin enable not followed");

	// Sequencing and select cross-checks; done stays set until the next reset.
	a_done_sticky: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_config_done |=> o_config_done)
		else $error("config done dropped before reset");
	a_idle_refuse: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state == cce_pkg::ST_IDLE && ce_n) |=> !o_load_active)
		else $error("load started with enable high");
	a_user_out_follow: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state == cce_pkg::ST_USER && !i_dual_purpose_on) |=>
		(i_dual_purpose_on || o_chain_enable_out_n_o == $past(i_user_out)))
		else $error("user pin level not followed");
	a_select_exclusive: assert property (@(posedge i_mclk) disable iff (i_rst)
		!(!o_serial_boot_select_n && !o_parallel_boot_select_n))
		else $error("both boot selects active");
	a_select_after_load: assert property (@(posedge i_mclk) disable iff (i_rst)
		(o_load_active && i_load_done && !ce_n) |=>
		(o_serial_boot_select_n && o_parallel_boot_select_n && o_config_done))
		else $error("selects or done wrong after load");
	a_serial_mode_only: assert property (@(posedge i_mclk) disable iff (i_rst)
		!o_serial_boot_select_n |-> $past(active_serial_boot))
		else $error("serial select outside serial mode");
	a_parallel_mode_only: assert property (@(posedge i_mclk) disable iff (i_rst)
		!o_parallel_boot_select_n |-> $past(active_parallel_boot))
		else $error("parallel select outside parallel mode");
endmodule

/* File: dv/cce_mem_model.sv */
// Boot memory model that signals the end of loading after a fixed read time.
`timescale 1ns/100ps
module cce_mem_model #(
	parameter int READ_CYCLES = 4
) (
	input wire logic i_mclk,
	input wire logic i_select_n,
	output logic o_load_done
);
	int cnt = 0;
	initial o_load_done = 1'b0;
	// Counts while selected and pulses once; deselecting restarts the read.
	always @(posedge i_mclk) begin
		o_load_done <= #1 (cnt == READ_CYCLES);
		cnt <= i_select_n ? 0 : cnt + 1;
	end
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the chain enable control block.
`timescale 1ns/100ps
module testbench;
	logic i_mclk = 0;
	logic i_rst = 1;
	logic ce_n = 1;
	logic st = 0;
	logic ini = 0;
	logic dp_on = 1;
	logic u_out = 0;
	logic u_oe = 0;
	logic [1:0] mode = cce_pkg::MODE_ACTIVE_SERIAL;
	logic ld_en, ld_act, done, u_in, ce_o, ce_oe, ser_n, par_n, ld_done;
	// The chain pin has a pull-up, so released means high.
	wire pin = ce_oe ? ce_o : 1'b1;
	int err_total = 0;
	int checks = 0;
	always #10 i_mclk = ~i_mclk;
	cce_ctrl uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_chain_enable_in_n(ce_n), .i_boot_mode(mode),
		.i_load_start(st), .i_load_done(ld_done), .i_init_done(ini), .i_dual_purpose_on(dp_on),
		.i_user_out(u_out), .i_user_oe(u_oe), .i_chain_enable_out_pin(pin), .o_load_enable(ld_en),
		.o_load_active(ld_act), .o_config_done(done), .o_user_in(u_in),
		.o_chain_enable_out_n_o(ce_o), .o_chain_enable_out_n_oe(ce_oe),
		.o_serial_boot_select_n(ser_n), .o_parallel_boot_select_n(par_n));
	cce_mem_model mem (.i_mclk(i_mclk), .i_select_n(ser_n & par_n), .o_load_done(ld_done));
	// ==========================================================
	// Shared tasks.
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task automatic chk(input string name, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic restart(input logic [1:0] m);
		i_rst = 1;
		mode = m;
		ce_n = 0;
		cyc(2);
		i_rst = 0;
		cyc(3);
	endtask
	// ==========================================================
	// Scenarios.
	task automatic t_refuse;
		st = 1;
		cyc(6);
		chk("load_enable", 1'b0, ld_en);
		chk("load_active", 1'b0, ld_act);
		chk("serial_sel", 1'b1, ser_n);
		chk("chain_oe", 1'b0, ce_oe);
		st = 0;
		$display("end refuse");
	endtask
	task automatic t_boot(input logic [1:0] m);
		int n;
		restart(m);
		st = 1;
		cyc(1);
		st = 0;
		chk("load_active", 1'b1, ld_act);
		chk("load_enable", 1'b1, ld_en);
		chk("serial_sel", m != cce_pkg::MODE_ACTIVE_SERIAL, ser_n);
		chk("parallel_sel", m != cce_pkg::MODE_ACTIVE_PARALLEL, par_n);
		chk("chain_oe", 1'b0, ce_oe);
		for (n = 0; n < 20 && done !== 1'b1; n++)
			cyc(1);
		chk("config_done", 1'b1, done);
		chk("chain_pin", 1'b0, pin);
		chk("select_off", 1'b1, ser_n & par_n);
		ini = 1;
		cyc(1);
		ini = 0;
		cyc(2);
		$display("end boot mode %0d", m);
	endtask
	task automatic t_user;
		dp_on = 0;
		t_boot(cce_pkg::MODE_ACTIVE_SERIAL);
		u_out = 1;
		u_oe = 1;
		cyc(3);
		chk("user_drive", 1'b1, ce_o);
		chk("user_oe", 1'b1, ce_oe);
		chk("user_in", 1'b1, u_in);
		u_out = 0;
		cyc(3);
		chk("user_drive_low", 1'b0, ce_o);
		chk("user_in_low", 1'b0, u_in);
		u_oe = 0;
		cyc(3);
		chk("user_release", 1'b0, ce_oe);
		chk("user_in_pullup", 1'b1, u_in);
		dp_on = 1;
		$display("end user");
	endtask
	task automatic t_abort;
		restart(cce_pkg::MODE_ACTIVE_SERIAL);
		st = 1;
		cyc(1);
		st = 0;
		ce_n = 1;
		cyc(4);
		chk("abort_enable", 1'b0, ld_en);
		chk("abort_active", 1'b0, ld_act);
		chk("abort_sel", 1'b1, ser_n);
		chk("abort_done", 1'b0, done);
		$display("end abort");
	endtask
	task automatic t_passive;
		restart(cce_pkg::MODE_PASSIVE);
		st = 1;
		cyc(1);
		st = 0;
		chk("passive_active", 1'b1, ld_act);
		chk("passive_sel", 1'b1, ser_n & par_n);
		cyc(8);
		chk("passive_sel_hold", 1'b1, ser_n & par_n);
		chk("passive_done", 1'b0, done);
		chk("passive_oe", 1'b0, ce_oe);
		$display("end passive");
	endtask
	// Main sequence.
	initial begin
		cyc(16);
		i_rst = 0;
		t_refuse();
		t_boot(cce_pkg::MODE_ACTIVE_SERIAL);
		chk("dual_keep", 1'b1, ce_oe);
		t_boot(cce_pkg::MODE_ACTIVE_PARALLEL);
		t_user();
		t_passive();
		t_abort();
		results();
	end
	// Watchdog against a hang.
	initial begin
		#20000;
		err_total++;
		results();
	end
endmodule
